// file: logic/nme_pkg.sv
// Package for the NAND mode, wait status and parity result block
// ============================================================
// Overview of operation
// (RULE1) Control bits 11..8 start parity accumulation for the four selects.
// (RULE2) Control bits 3..0 mark a select as having NAND flash attached.
// (RULE3) Status bits 3..0 show the raw level of the four wait pins.
// (RULE4) Wait polarity never inverts the raw wait status field.
// (RULE5) Eight-bit flash: weights 1..4 are column, 8..2048 row parities.
// (RULE6) Sixteen-bit flash: weights 1..8 are column, 16..2048 row parities.
// (RULE7) Result: odd set in 27..16, even set in 11..0, others zero.
// (RULE8) Parity bits read-only, updated by NAND accesses, reset to zero.
// (RULE9) Four independent result registers, one per select.
// (RULE10) Writing a start bit clears that result and begins accumulating.
// (RULE11) Software sets mode before start and reads result after transfer.
package nme_pkg;
   // ============================================================
   // Register map (byte addresses)
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_WAIT = 8'h04;
   localparam logic [7:0] OFS_RES0 = 8'h08;
   localparam logic [7:0] OFS_RES3 = 8'h14;
   localparam logic [7:0] OFS_CFG = 8'h18;
   // ============================================================
   // Field positions and sizes
   localparam int CTRL_MODE_LSB = 0;
   localparam int CTRL_START_LSB = 8;
   localparam int RES_EVEN_LSB = 0;
   localparam int RES_ODD_LSB = 16;
   localparam int CFG_WIDE_BIT = 0;
   localparam int NSEL = 4;
   localparam int NPAR = 12;
   localparam int LANES = 16;
   // ============================================================
   // Reset values and position steps
   localparam logic [3:0] RST_MODE = 4'h0;
   localparam logic [3:0] RST_START = 4'h0;
   localparam logic [11:0] RST_PAR = 12'h000;
   localparam logic RST_WIDE = 1'b0;
   localparam logic [11:0] STEP_NARROW = 12'h008;
   localparam logic [11:0] STEP_WIDE = 12'h010;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [7:0] paddr;
      logic [31:0] pwdata;
   } nme_apb_req_s;

   typedef struct packed {
      logic valid;
      logic [1:0] sel;
      logic [15:0] data;
   } nme_access_s;

   typedef struct packed {
      logic [3:0] mode;
      logic [3:0] ecc_on;
      logic wide;
      logic [3:0] wait_lvl;
      logic [3:0][11:0] odd;
      logic [3:0][11:0] even;
      logic [3:0][11:0] pos;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } nme_state_s;
endpackage

// file: logic/nme_top.sv
// APB register slice: NAND mode, raw wait status and per-select parity
module nme_top (
   input wire logic pclk,
   input wire logic presetn,
   input wire nme_pkg::nme_apb_req_s apb_req,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire nme_pkg::nme_access_s nand_access,
   input wire logic [3:0] external_wait_pin,
   output logic [3:0] nand_mode
);
   nme_pkg::nme_state_s st_r;
   nme_pkg::nme_state_s st_nxt;
   logic acc_phase;
   logic wr_done;

   // ============================================================
   // Bus decode
   // Every access answers in its first access cycle; no wait states.
   assign acc_phase = apb_req.psel & apb_req.penable & st_r.pready;
   assign wr_done = acc_phase & apb_req.pwrite;

   // ============================================================
   // Next state
   always_comb begin
      logic [11:0] p;
      logic [3:0] start_req;
      logic [2:0] ridx;
      p = '0;
      start_req = '0;
      ridx = '0;
      st_nxt = st_r;
      st_nxt.wait_lvl = external_wait_pin; // RULE3 RULE4
      st_nxt.pready = 1'b0;
      st_nxt.pslverr = 1'b0;
      // Parity accumulation over one access; data lanes beyond width ignored
      if (nand_access.valid && st_r.ecc_on[nand_access.sel] &&
          st_r.mode[nand_access.sel]) begin // RULE8 RULE9
         for (int b = 0; b < nme_pkg::LANES; b++) begin
            if (st_r.wide || b < 8) begin
               p = st_r.pos[nand_access.sel] + 12'(b);
               for (int k = 0; k < nme_pkg::NPAR; k++) begin
                  // Low position bits are column, the rest row terms
                  if (p[k]) begin // RULE5 RULE6
                     st_nxt.odd[nand_access.sel][k] =
                        st_nxt.odd[nand_access.sel][k] ^ nand_access.data[b];
                  end else begin
                     st_nxt.even[nand_access.sel][k] =
                        st_nxt.even[nand_access.sel][k] ^ nand_access.data[b];
                  end
               end
            end
         end
         st_nxt.pos[nand_access.sel] = st_r.pos[nand_access.sel] +
            (st_r.wide ? nme_pkg::STEP_WIDE : nme_pkg::STEP_NARROW); // RULE5 RULE6
      end
      // Register writes take effect on the completing edge only
      if (wr_done) begin
         case (apb_req.paddr)
            nme_pkg::OFS_CTRL: begin
               st_nxt.mode = apb_req.pwdata[nme_pkg::CTRL_MODE_LSB +: 4]; // RULE2
               start_req = apb_req.pwdata[nme_pkg::CTRL_START_LSB +: 4];
               st_nxt.ecc_on = start_req; // RULE1
               for (int s = 0; s < nme_pkg::NSEL; s++) begin
                  // Start wins over an access in the same cycle
                  if (start_req[s]) begin // RULE10
                     st_nxt.odd[s] = nme_pkg::RST_PAR;
                     st_nxt.even[s] = nme_pkg::RST_PAR;
                     st_nxt.pos[s] = '0;
                  end
               end
            end
            nme_pkg::OFS_CFG: begin
               st_nxt.wide = apb_req.pwdata[nme_pkg::CFG_WIDE_BIT];
            end
            default: begin
            end
         endcase
      end
      // Read data prepared during setup so it is a flop at the answer
      if (apb_req.psel && !apb_req.penable) begin
         st_nxt.pready = 1'b1;
         st_nxt.prdata = '0;
         ridx = 3'((apb_req.paddr - nme_pkg::OFS_RES0) >> 2);
         case (apb_req.paddr)
            nme_pkg::OFS_CTRL: begin
               st_nxt.prdata[nme_pkg::CTRL_MODE_LSB +: 4] = st_r.mode;
               st_nxt.prdata[nme_pkg::CTRL_START_LSB +: 4] = st_r.ecc_on;
            end
            nme_pkg::OFS_WAIT: begin
               st_nxt.prdata[3:0] = st_r.wait_lvl; // RULE3 RULE4
            end
            nme_pkg::OFS_CFG: begin
               st_nxt.prdata[nme_pkg::CFG_WIDE_BIT] = st_r.wide;
            end
            default: begin
               if (apb_req.paddr >= nme_pkg::OFS_RES0 &&
                   apb_req.paddr <= nme_pkg::OFS_RES3 && apb_req.paddr[1:0] == 2'b00) begin
                  st_nxt.prdata[nme_pkg::RES_ODD_LSB +: 12] = st_r.odd[ridx[1:0]]; // RULE7
                  st_nxt.prdata[nme_pkg::RES_EVEN_LSB +: 12] = st_r.even[ridx[1:0]];
                  // Result registers ignore writes
                  st_nxt.pslverr = apb_req.pwrite; // RULE8
               end else begin
                  st_nxt.pslverr = 1'b1;
               end
            end
         endcase
      end
   end

   // ============================================================
   // State register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r.mode <= nme_pkg::RST_MODE;
         st_r.ecc_on <= nme_pkg::RST_START;
         st_r.wide <= nme_pkg::RST_WIDE;
         st_r.wait_lvl <= 4'h0;
         st_r.odd <= '0; // RULE8
         st_r.even <= '0;
         st_r.pos <= '0;
         st_r.pready <= 1'b0;
         st_r.pslverr <= 1'b0;
         st_r.prdata <= 32'h0000_0000;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign prdata = st_r.prdata;
   assign pready = st_r.pready;
   assign pslverr = st_r.pslverr;
   assign nand_mode = st_r.mode;

   // ============================================================
   // Checks
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   logic acc_ok;
   assign acc_ok = nand_access.valid & st_r.ecc_on[nand_access.sel] &
      st_r.mode[nand_access.sel];

   AST_START_BIT: assert property ( // RULE1
      wr_done && apb_req.paddr == nme_pkg::OFS_CTRL |=> st_r.ecc_on == $past(apb_req.pwdata[11:8]))
      else $error("Start bits not stored");
   AST_MODE_BIT: assert property ( // RULE2
      wr_done && apb_req.paddr == nme_pkg::OFS_CTRL |=> nand_mode == $past(apb_req.pwdata[3:0]))
      else $error("Mode bits not stored");
   AST_WAIT_RAW: assert property ( // RULE3
      apb_req.psel && !apb_req.penable && apb_req.paddr == nme_pkg::OFS_WAIT
      |=> prdata[3:0] == $past(external_wait_pin, 2))
      else $error("Wait status not raw pin level");
   AST_WAIT_UPPER: assert property ( // RULE4
      apb_req.psel && !apb_req.penable && apb_req.paddr == nme_pkg::OFS_WAIT
      |=> pready && prdata[31:4] == 28'h0000000)
      else $error("Wait status upper bits set");
   AST_STEP_NARROW: assert property ( // RULE5
      acc_ok && !st_r.wide && !wr_done
      |=> st_r.pos[$past(nand_access.sel)] == $past(st_r.pos[nand_access.sel]) + 12'h008)
      else $error("Narrow step wrong");
   AST_STEP_WIDE: assert property ( // RULE6
      acc_ok && st_r.wide && !wr_done
      |=> st_r.pos[$past(nand_access.sel)] == $past(st_r.pos[nand_access.sel]) + 12'h010)
      else $error("Wide step wrong");
   AST_RES_RSVD: assert property ( // RULE7
      apb_req.psel && !apb_req.penable && apb_req.paddr == nme_pkg::OFS_RES0
      |=> prdata[31:28] == 4'h0 && prdata[15:12] == 4'h0 && prdata[27:16] == $past(st_r.odd[0]))
      else $error("Result layout wrong");
   AST_HOLD: assert property ( // RULE8
      !acc_ok && !wr_done |=> $stable(st_r.odd) && $stable(st_r.even))
      else $error("Parity changed without access");
   AST_SEPARATE: assert property ( // RULE9
      acc_ok && nand_access.sel == 2'b00 && !wr_done |=> $stable(st_r.odd[1]))
      else $error("Other select parity changed");
   AST_START_CLR: assert property ( // RULE10
      wr_done && apb_req.paddr == nme_pkg::OFS_CTRL && apb_req.pwdata[8]
      |=> st_r.odd[0] == 12'h000 && st_r.even[0] == 12'h000 && st_r.pos[0] == 12'h000)
      else $error("Start did not clear result");
endmodule

// file: sim/nme_flash_model.sv
// Far-side flash model: drives data accesses onto the parity port
module nme_flash_model (
   input wire logic pclk,
   output nme_pkg::nme_access_s nand_access
);
   timeunit 1ns;
   timeprecision 1ps;
   logic busy = 1'b0;
   initial nand_access = '0;
   // Idle bus keeps toggling so a stale word is never mistaken for data
   always @(posedge pclk) begin
      if (!busy) nand_access.data <= ~nand_access.data;
   end
   task automatic burst(input logic [1:0] sel, input int n, input int gap);
      busy = 1'b1;
      for (int i = 0; i < n; i++) begin
         @(posedge pclk);
         nand_access <= '{1'b1, sel, 16'($urandom)};
         repeat (gap) @(posedge pclk) nand_access.valid <= 1'b0;
      end
      @(posedge pclk);
      nand_access.valid <= 1'b0;
      busy = 1'b0;
   endtask
endmodule

// file: sim/nme_top_tb.sv
// Self-checking bench for the NAND mode, wait status and parity slice
module nme_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   nme_pkg::nme_apb_req_s req = '0;
   nme_pkg::nme_access_s acc;
   logic [31:0] prdata, r;
   logic pready, pslverr, e;
   logic [3:0] pins = 4'h0, nand_mode, em = 4'h0, es = 4'h0, v;
   logic [3:0][11:0] eo = '0, ee = '0, ep = '0;
   logic ew = 1'b0;
   logic [11:0] c;
   int failures = 0, checks_done = 0;
   initial forever #10 pclk = ~pclk;
   nme_top dut_u (.pclk(pclk), .presetn(presetn), .apb_req(req), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .nand_access(acc), .external_wait_pin(pins),
      .nand_mode(nand_mode));
   nme_flash_model flash_u (.pclk(pclk), .nand_access(acc));
   // ============================================================
   // Reference parity: bit position selects odd or even set per weight
   always @(posedge pclk) begin
      if (presetn === 1'b1 && acc.valid === 1'b1 && em[acc.sel] && es[acc.sel]) begin
         for (int b = 0; b < (ew ? 16 : 8); b++)
            for (int k = 0; k < 12; k++)
               if (12'(ep[acc.sel] + 12'(b)) >> k & 12'h001) eo[acc.sel][k] ^= acc.data[b];
               else ee[acc.sel][k] ^= acc.data[b];
         ep[acc.sel] += ew ? 12'h010 : 12'h008;
      end
   end
   // ============================================================
   // Bus tasks and checks
   task automatic final_report();
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] x, input logic [31:0] s);
      checks_done++;
      if (s !== x) begin
         failures++;
         $display("ERROR %s expected %h seen %h", n, x, s);
      end
   endtask
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      // Idle edge first so a release and a new setup never share a time step
      @(posedge pclk);
      req <= '{1'b1, 1'b0, w, a, d};
      @(posedge pclk) req.penable <= 1'b1;
      // Look at the answer mid-cycle, where the flops have settled
      do begin
         @(negedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         failures++;
         final_report();
      end
      r = prdata;
      e = pslverr;
      // Request held through the edge at which pready is sampled high
      @(posedge pclk);
      req.psel <= 1'b0;
      req.penable <= 1'b0;
   endtask
   // ============================================================
   // Scenarios
   initial begin
      void'($urandom(45615));
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      for (int a = 0; a < 8'h1C; a += 4) begin
         xfer(1'b0, 8'(a), '0);
         chk("reset value", '0, r);
      end
      $display("test reset values done");
      repeat (6) begin
         v = 4'($urandom);
         pins <= v;
         repeat (3) @(posedge pclk);
         xfer(1'b0, nme_pkg::OFS_WAIT, '1);
         chk("raw wait", {28'h0, v}, r);
      end
      $display("test wait status done");
      xfer(1'b1, nme_pkg::OFS_RES3, '1);
      chk("result write error", 32'h1, {31'h0, e});
      xfer(1'b0, 8'h1C, '0);
      chk("unmapped read", 32'h1, {31'h0, e});
      chk("unmapped data", '0, r);
      xfer(1'b0, nme_pkg::OFS_RES3, '0);
      chk("result kept", '0, r);
      $display("test refusals done");
      for (int t = 0; t < 6; t++) begin
         ew = t[0];
         xfer(1'b1, nme_pkg::OFS_CFG, {31'h0, ew});
         c = t == 5 ? 12'hF0F : 12'($urandom) & 12'hF0F;
         xfer(1'b1, nme_pkg::OFS_CTRL, {28'h0, c[3:0]});
         xfer(1'b1, nme_pkg::OFS_CTRL, {20'h0, c});
         em = c[3:0];
         es = c[11:8];
         for (int s = 0; s < 4; s++)
            if (es[s]) {eo[s], ee[s], ep[s]} = '0;
         xfer(1'b0, nme_pkg::OFS_CTRL, '0);
         chk("mode pins", {28'h0, em}, {28'h0, nand_mode});
         chk("control", {20'h0, c}, r);
         for (int s = 0; s < 4; s++) flash_u.burst(2'(s), 1 + $urandom % 300, $urandom % 3);
         for (int s = 0; s < 4; s++) begin
            xfer(1'b0, 8'(nme_pkg::OFS_RES0 + 4 * s), '0);
            chk("parity", {4'h0, eo[s], 4'h0, ee[s]}, r);
         end
      end
      $display("test parity done");
      final_report();
   end
endmodule
